// ===== hdl/rdrv_ctrl.sv
// re-driver control: pin decode, power state machine, receiver detect, register slave
`timescale 1ns/1ps
`include "rdrv_regs.svh"

module rdrv_ctrl
	import rdrv_pkg::*;
#(
	parameter int unsigned PROBE_CYC = `RDRV_PROBE_CYC,
	parameter int unsigned SETTLE_CYC = `RDRV_SETTLE_CYC,
	parameter int unsigned IDLE_CYC = `RDRV_IDLE_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [`RDRV_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [`RDRV_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic enable_pin,
	input wire logic [1:0] ch1_rx_boost_select,
	input wire logic ch1_tx_swing_select,
	input wire logic [1:0] ch1_tx_emphasis_select,
	input wire logic ch1_lfps_present,
	input wire logic ch1_signal_present,
	input wire logic ch1_far_end_present,
	input wire logic [1:0] ch2_rx_boost_select,
	input wire logic ch2_tx_swing_select,
	input wire logic [1:0] ch2_tx_emphasis_select,
	input wire logic ch2_lfps_present,
	input wire logic ch2_signal_present,
	input wire logic ch2_far_end_present,
	output rdrv_gain_type ch1_gain,
	output rdrv_swing_type ch1_swing,
	output rdrv_emph_type ch1_emph,
	output rdrv_gain_type ch2_gain,
	output rdrv_swing_type ch2_swing,
	output rdrv_emph_type ch2_emph,
	output logic rx_term_en,
	output logic redrive_en,
	output logic low_power,
	output logic rx_detect_probe,
	output rdrv_state_type power_state
);

	// ----------------------------------------
	// channels
	// ----------------------------------------
	logic ch1_lfps;
	logic ch2_lfps;
	logic ch1_traffic;
	logic ch2_traffic;
	logic ch1_far;
	logic ch2_far;
	logic traffic_any;

	// each channel owns its own synchronisers and settings
	rdrv_chan_cfg u_ch1 (
		.aclk(aclk),
		.aresetn(aresetn),
		.rx_boost_select(ch1_rx_boost_select),
		.tx_swing_select(ch1_tx_swing_select),
		.tx_emphasis_select(ch1_tx_emphasis_select),
		.lfps_present(ch1_lfps_present),
		.signal_present(ch1_signal_present),
		.far_end_present(ch1_far_end_present),
		.gain_r(ch1_gain),
		.swing_r(ch1_swing),
		.emph_r(ch1_emph),
		.lfps_r(ch1_lfps),
		.traffic_r(ch1_traffic),
		.far_end_r(ch1_far)
	);

	rdrv_chan_cfg u_ch2 (
		.aclk(aclk),
		.aresetn(aresetn),
		.rx_boost_select(ch2_rx_boost_select),
		.tx_swing_select(ch2_tx_swing_select),
		.tx_emphasis_select(ch2_tx_emphasis_select),
		.lfps_present(ch2_lfps_present),
		.signal_present(ch2_signal_present),
		.far_end_present(ch2_far_end_present),
		.gain_r(ch2_gain),
		.swing_r(ch2_swing),
		.emph_r(ch2_emph),
		.lfps_r(ch2_lfps),
		.traffic_r(ch2_traffic),
		.far_end_r(ch2_far)
	);

	assign traffic_any = ch1_traffic | ch2_traffic;

	// ----------------------------------------
	// enable pin
	// ----------------------------------------
	logic en1_r;
	logic en2_r;
	logic en3_r;
	logic en_ok_r;
	logic soft_off_r;
	logic probe_req_r;
	logic active;

	// three stages, level moves when stages two and three agree
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			en1_r <= 1'h0;
			en2_r <= 1'h0;
			en3_r <= 1'h0;
			en_ok_r <= 1'h0;
		end else begin
			en1_r <= enable_pin;
			en2_r <= en1_r;
			en3_r <= en2_r;
			if (en2_r == en3_r) begin
				en_ok_r <= en3_r;
			end
		end
	end

	assign active = en_ok_r & ~soft_off_r;

	// ----------------------------------------
	// probe divider and detect window
	// ----------------------------------------
	logic [15:0] tick_cnt_r;
	logic tick;
	logic [15:0] settle_cnt_r;
	logic probe_r;
	logic probe_done_r;
	logic found_r;
	logic probe_allowed;
	rdrv_state_type state_r;
	rdrv_state_type state_nxt;

	assign tick = (tick_cnt_r == 16'(PROBE_CYC - 1));
	assign probe_allowed = (state_r == RDRV_DISCONNECT) || (state_r == RDRV_U2U3)
		|| (state_r == RDRV_U0 && !traffic_any);

	// divider giving one enable pulse per probe period
	always_ff @(posedge aclk) begin
		if (!aresetn || !active || tick) begin
			tick_cnt_r <= 16'h0000;
		end else begin
			tick_cnt_r <= tick_cnt_r + 16'h0001;
		end
	end

	// probe window, result sampled at its end on both ports
	always_ff @(posedge aclk) begin
		if (!aresetn || !active || state_r == RDRV_SHUTDOWN) begin
			probe_r <= 1'h0;
			settle_cnt_r <= 16'h0000;
			probe_done_r <= 1'h0;
			found_r <= 1'h0;
		end else if (probe_r) begin
			if (settle_cnt_r == 16'(SETTLE_CYC - 1)) begin
				probe_r <= 1'h0;
				settle_cnt_r <= 16'h0000;
				probe_done_r <= 1'h1;
				found_r <= ch1_far & ch2_far;
			end else begin
				settle_cnt_r <= settle_cnt_r + 16'h0001;
				probe_done_r <= 1'h0;
			end
		end else begin
			probe_done_r <= 1'h0;
			if ((tick || probe_req_r) && probe_allowed) begin
				probe_r <= 1'h1;
			end
		end
	end

	// ----------------------------------------
	// power state machine
	// ----------------------------------------
	logic [15:0] idle_cnt_r;

	// idle time, restarted by any traffic
	always_ff @(posedge aclk) begin
		if (!aresetn || state_r != RDRV_U0 || traffic_any) begin
			idle_cnt_r <= 16'h0000;
		end else if (idle_cnt_r != 16'(IDLE_CYC - 1)) begin
			idle_cnt_r <= idle_cnt_r + 16'h0001;
		end
	end

	// next mode
	always_comb begin
		state_nxt = state_r;
		if (!active) begin
			state_nxt = RDRV_SHUTDOWN;
		end else begin
			case (state_r)
				RDRV_SHUTDOWN: state_nxt = RDRV_DISCONNECT;
				RDRV_DISCONNECT: begin
					if (probe_done_r && found_r) begin
						state_nxt = RDRV_U0;
					end
				end
				RDRV_U0: begin
					if (probe_done_r && !found_r) begin
						state_nxt = RDRV_DISCONNECT;
					end else if (!traffic_any && idle_cnt_r == 16'(IDLE_CYC - 1)) begin
						state_nxt = RDRV_U2U3;
					end
				end
				RDRV_U2U3: begin
					if (probe_done_r && !found_r) begin
						state_nxt = RDRV_DISCONNECT;
					end else if (traffic_any) begin
						state_nxt = RDRV_U0;
					end
				end
				default: state_nxt = RDRV_SHUTDOWN;
			endcase
		end
	end

	// mode register and the outputs it steers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= RDRV_SHUTDOWN;
			rx_term_en <= 1'h0;
			redrive_en <= 1'h0;
			low_power <= 1'h0;
			rx_detect_probe <= 1'h0;
			power_state <= RDRV_SHUTDOWN;
		end else begin
			state_r <= state_nxt;
			rx_term_en <= (state_nxt == RDRV_U0) || (state_nxt == RDRV_U2U3);
			redrive_en <= (state_nxt == RDRV_U0);
			low_power <= (state_nxt == RDRV_U2U3);
			rx_detect_probe <= probe_r;
			power_state <= state_nxt;
		end
	end

	// ----------------------------------------
	// register slave
	// ----------------------------------------
	logic [`RDRV_ADDR_W-1:0] awaddr_r;
	logic [31:0] wdata_r;
	logic wbyte0_r;
	logic wr_fire;
	logic [31:0] status_word;
	logic [31:0] settings_word;

	assign wr_fire = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;

	assign status_word = {25'h0000000, traffic_any, probe_r, en_ok_r, rx_term_en, found_r,
		state_r};
	assign settings_word = {19'h00000, ch2_emph, ch2_swing, ch2_gain, 3'h0, ch1_emph,
		ch1_swing, ch1_gain};

	// address and data taken in either order, response once both are in
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'h1;
			s_axi_wready <= 1'h1;
			s_axi_bvalid <= 1'h0;
			s_axi_bresp <= `RDRV_RESP_OKAY;
			awaddr_r <= '0;
			wdata_r <= 32'h00000000;
			wbyte0_r <= 1'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'h0;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'h0;
				wdata_r <= s_axi_wdata;
				wbyte0_r <= s_axi_wstrb[0];
			end
			if (wr_fire) begin
				s_axi_bvalid <= 1'h1;
				s_axi_bresp <= (awaddr_r == `RDRV_CTRL_OFFSET || awaddr_r == `RDRV_STATUS_OFFSET
					|| awaddr_r == `RDRV_SETTINGS_OFFSET) ? `RDRV_RESP_OKAY : `RDRV_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'h0;
				s_axi_awready <= 1'h1;
				s_axi_wready <= 1'h1;
			end
		end
	end

	// control register, probe request is a write-one pulse
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			soft_off_r <= `RDRV_CTRL_RESET;
			probe_req_r <= 1'h0;
		end else begin
			probe_req_r <= 1'h0;
			if (wr_fire && wbyte0_r && awaddr_r == `RDRV_CTRL_OFFSET) begin
				soft_off_r <= wdata_r[`RDRV_CTRL_SOFT_OFF_BIT];
				probe_req_r <= wdata_r[`RDRV_CTRL_PROBE_BIT];
			end
		end
	end

	// read channel, data one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'h1;
			s_axi_rvalid <= 1'h0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RDRV_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'h0;
			s_axi_rvalid <= 1'h1;
			s_axi_rresp <= `RDRV_RESP_OKAY;
			case (s_axi_araddr)
				`RDRV_CTRL_OFFSET: s_axi_rdata <= {31'h00000000, soft_off_r};
				`RDRV_STATUS_OFFSET: s_axi_rdata <= status_word;
				`RDRV_SETTINGS_OFFSET: s_axi_rdata <= settings_word;
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `RDRV_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'h0;
			s_axi_arready <= 1'h1;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	localparam int PROBE_GAP_MAX = 2100;
	logic [15:0] u23_gap_r;

	// cycles in low power since the last probe ended
	always_ff @(posedge aclk) begin
		if (!aresetn || state_r != RDRV_U2U3 || probe_r) begin
			u23_gap_r <= 16'h0000;
		end else if (u23_gap_r != 16'hFFFF) begin
			u23_gap_r <= u23_gap_r + 16'h0001;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_term_after_found;
		$rose(rx_term_en) |-> $past(probe_done_r && found_r) || $past(state_r == RDRV_U2U3);
	endproperty
	a_term_after_found: assert property (p_term_after_found) else $error("term without find");

	property p_u0_holds;
		(state_r == RDRV_U0 && traffic_any && active && !probe_done_r) |=> state_r == RDRV_U0;
	endproperty
	a_u0_holds: assert property (p_u0_holds) else $error("left U0 under traffic");

	property p_u23_probes;
		u23_gap_r < 16'(PROBE_GAP_MAX);
	endproperty
	a_u23_probes: assert property (p_u23_probes) else $error("no probe in low power");

	sequence s_disc_to_u0;
		state_r == RDRV_DISCONNECT ##1 state_r == RDRV_U0;
	endsequence
	property p_u0_needs_both;
		s_disc_to_u0 |-> $past(found_r && probe_done_r);
	endproperty
	a_u0_needs_both: assert property (p_u0_needs_both) else $error("U0 without both ports");

	property p_off_shutdown;
		!active |=> state_r == RDRV_SHUTDOWN && !rx_term_en && !redrive_en;
	endproperty
	a_off_shutdown: assert property (p_off_shutdown) else $error("not shut down");

	sequence s_pin_low;
		!enable_pin [*3];
	endsequence
	property p_pin_resets;
		s_pin_low |=> ##2 state_r == RDRV_SHUTDOWN;
	endproperty
	a_pin_resets: assert property (p_pin_resets) else $error("enable pin ignored");

	property p_loss_disconnect;
		(active && probe_done_r && !found_r && state_r != RDRV_DISCONNECT)
			|=> state_r == RDRV_DISCONNECT && !rx_term_en;
	endproperty
	a_loss_disconnect: assert property (p_loss_disconnect) else $error("loss kept term");

endmodule

// ===== hdl/rdrv_regs.svh
// register offsets, field positions, reset values, pin codes and timing of the re-driver control
`ifndef RDRV_REGS_SVH
`define RDRV_REGS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define RDRV_ADDR_W 8
`define RDRV_CTRL_OFFSET 8'h00
`define RDRV_STATUS_OFFSET 8'h04
`define RDRV_SETTINGS_OFFSET 8'h08

// ----------------------------------------
// control fields and reset value
// ----------------------------------------
`define RDRV_CTRL_SOFT_OFF_BIT 0
`define RDRV_CTRL_PROBE_BIT 1
`define RDRV_CTRL_RESET 1'h0

// ----------------------------------------
// status fields
// ----------------------------------------
`define RDRV_STAT_STATE_LSB 0
`define RDRV_STAT_FOUND_BIT 2
`define RDRV_STAT_TERM_BIT 3
`define RDRV_STAT_ENABLE_BIT 4
`define RDRV_STAT_PROBE_BIT 5
`define RDRV_STAT_TRAFFIC_BIT 6

// ----------------------------------------
// settings fields, channel 2 sits one byte above channel 1
// ----------------------------------------
`define RDRV_SET_GAIN_LSB 0
`define RDRV_SET_SWING_BIT 2
`define RDRV_SET_EMPH_LSB 3
`define RDRV_SET_CH2_SHIFT 8

// ----------------------------------------
// three-level pin codes from the pad comparators
// ----------------------------------------
`define RDRV_PIN_LOW 2'h0
`define RDRV_PIN_FLOAT 2'h1
`define RDRV_PIN_HIGH 2'h2

// ----------------------------------------
// bus responses
// ----------------------------------------
`define RDRV_RESP_OKAY 2'h0
`define RDRV_RESP_SLVERR 2'h2

// ----------------------------------------
// timing, times in ns, counts in cycles of aclk
// ----------------------------------------
`define RDRV_CLK_PERIOD_NS 50
`define RDRV_PROBE_PERIOD_NS 100000
`define RDRV_SETTLE_NS 1000
`define RDRV_IDLE_NS 10000
`define RDRV_PROBE_CYC (`RDRV_PROBE_PERIOD_NS / `RDRV_CLK_PERIOD_NS)
`define RDRV_SETTLE_CYC ((`RDRV_SETTLE_NS + `RDRV_CLK_PERIOD_NS - 1) / `RDRV_CLK_PERIOD_NS)
`define RDRV_IDLE_CYC ((`RDRV_IDLE_NS + `RDRV_CLK_PERIOD_NS - 1) / `RDRV_CLK_PERIOD_NS)

`endif

// ===== hdl/rdrv_pkg.sv
// types shared by the re-driver control modules
package rdrv_pkg;

	// receiver equalizer gain setting
	typedef enum logic [1:0] {
		RDRV_GAIN_3DB = 2'h0,
		RDRV_GAIN_6DB = 2'h1,
		RDRV_GAIN_9DB = 2'h2
	} rdrv_gain_type;

	// transition-bit output swing
	typedef enum logic {
		RDRV_SWING_0P9 = 1'h0,
		RDRV_SWING_1P1 = 1'h1
	} rdrv_swing_type;

	// transmit de-emphasis ratio
	typedef enum logic [1:0] {
		RDRV_EMPH_0DB = 2'h0,
		RDRV_EMPH_M3P5DB = 2'h1,
		RDRV_EMPH_M6P2DB = 2'h2
	} rdrv_emph_type;

	// power modes
	typedef enum logic [1:0] {
		RDRV_SHUTDOWN = 2'h0,
		RDRV_DISCONNECT = 2'h1,
		RDRV_U0 = 2'h2,
		RDRV_U2U3 = 2'h3
	} rdrv_state_type;

endpackage

// ===== hdl/rdrv_chan_cfg.sv
// one channel: pin synchronisers and setting decode
`timescale 1ns/1ps
`include "rdrv_regs.svh"

module rdrv_chan_cfg
	import rdrv_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [1:0] rx_boost_select,
	input wire logic tx_swing_select,
	input wire logic [1:0] tx_emphasis_select,
	input wire logic lfps_present,
	input wire logic signal_present,
	input wire logic far_end_present,
	output rdrv_gain_type gain_r,
	output rdrv_swing_type swing_r,
	output rdrv_emph_type emph_r,
	output logic lfps_r,
	output logic traffic_r,
	output logic far_end_r
);

	// ----------------------------------------
	// synchronisers
	// ----------------------------------------
	logic [7:0] raw;
	logic [7:0] sync1_r;
	logic [7:0] sync2_r;
	logic [7:0] sync3_r;
	logic [7:0] clean_r;
	logic [7:0] agree;

	assign raw = {rx_boost_select, tx_swing_select, tx_emphasis_select,
		lfps_present, signal_present, far_end_present};
	assign agree = ~(sync2_r ^ sync3_r);

	// three stage chain per pin
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_r <= 8'h00;
			sync2_r <= 8'h00;
			sync3_r <= 8'h00;
		end else begin
			sync1_r <= raw;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
		end
	end

	// a bit moves only once stages two and three agree
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clean_r <= 8'h00;
		end else begin
			clean_r <= (sync3_r & agree) | (clean_r & ~agree);
		end
	end

	// ----------------------------------------
	// decode
	// ----------------------------------------
	// equalizer gain, float or unknown code gives the middle gain
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gain_r <= RDRV_GAIN_3DB;
		end else begin
			case (clean_r[7:6])
				`RDRV_PIN_LOW: gain_r <= RDRV_GAIN_3DB;
				`RDRV_PIN_HIGH: gain_r <= RDRV_GAIN_9DB;
				default: gain_r <= RDRV_GAIN_6DB;
			endcase
		end
	end

	// output swing
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			swing_r <= RDRV_SWING_0P9;
		end else begin
			swing_r <= clean_r[5] ? RDRV_SWING_1P1 : RDRV_SWING_0P9;
		end
	end

	// de-emphasis, forced off while lfps is sensed, same map at both swings
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			emph_r <= RDRV_EMPH_0DB;
		end else if (clean_r[2]) begin
			emph_r <= RDRV_EMPH_0DB;
		end else begin
			case (clean_r[4:3])
				`RDRV_PIN_LOW: emph_r <= RDRV_EMPH_0DB;
				`RDRV_PIN_HIGH: emph_r <= RDRV_EMPH_M6P2DB;
				default: emph_r <= RDRV_EMPH_M3P5DB;
			endcase
		end
	end

	// line status towards the state machine
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lfps_r <= 1'h0;
			traffic_r <= 1'h0;
			far_end_r <= 1'h0;
		end else begin
			lfps_r <= clean_r[2];
			traffic_r <= clean_r[1] | clean_r[2];
			far_end_r <= clean_r[0];
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_gain_map;
		clean_r[7:6] == `RDRV_PIN_LOW |=> gain_r == RDRV_GAIN_3DB;
	endproperty
	a_gain_map: assert property (p_gain_map) else $error("gain decode wrong");

	property p_swing_map;
		##1 swing_r == (($past(clean_r[5])) ? RDRV_SWING_1P1 : RDRV_SWING_0P9);
	endproperty
	a_swing_map: assert property (p_swing_map) else $error("swing decode wrong");

	property p_emph_map;
		(!clean_r[2] && clean_r[4:3] == `RDRV_PIN_HIGH) |=> emph_r == RDRV_EMPH_M6P2DB;
	endproperty
	a_emph_map: assert property (p_emph_map) else $error("emphasis decode wrong");

	property p_lfps_no_emph;
		clean_r[2] |=> emph_r == RDRV_EMPH_0DB;
	endproperty
	a_lfps_no_emph: assert property (p_lfps_no_emph) else $error("emphasis on during lfps");

endmodule

// ===== verif/rdrv_far_end_model.sv
// far-end receiver model: loads each tx pair while attached
`timescale 1ns/1ps

module rdrv_far_end_model (
	input wire logic aclk,
	input wire logic rx_detect_probe,
	input wire logic [1:0] attached,
	output logic [1:0] far_end_present
);
	// detector result is only valid in a probe, else shows the inverse
	initial far_end_present = 2'h0;
	always @(posedge aclk) begin
		far_end_present <= rx_detect_probe ? attached : ~attached;
	end
endmodule

// ===== verif/rdrv_ctrl_tb_top.sv
// self-checking bench of the re-driver control
`timescale 1ns/1ps
`include "rdrv_regs.svh"
`define CHK(a, b) chk((a) === (b), `__LINE__)

module rdrv_ctrl_tb_top import rdrv_pkg::*;;
	localparam int PROBE = 50;
	localparam int IDLE = 20;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic s_axi_awvalid = 1'h0;
	logic s_axi_wvalid = 1'h0;
	logic s_axi_arvalid = 1'h0;
	logic s_axi_bready = 1'h1;
	logic s_axi_rready = 1'h1;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic enable_pin = 1'h1;
	logic [1:0] ch1_rx_boost_select = 2'h0;
	logic [1:0] ch2_rx_boost_select = 2'h0;
	logic [1:0] ch1_tx_emphasis_select = 2'h0;
	logic [1:0] ch2_tx_emphasis_select = 2'h0;
	logic ch1_tx_swing_select = 1'h0;
	logic ch2_tx_swing_select = 1'h0;
	logic [1:0] lfps = 2'h0;
	logic [1:0] sig = 2'h0;
	logic [1:0] att = 2'h0;
	logic [1:0] far;
	rdrv_gain_type ch1_gain, ch2_gain;
	rdrv_swing_type ch1_swing, ch2_swing;
	rdrv_emph_type ch1_emph, ch2_emph;
	logic rx_term_en, redrive_en, low_power, rx_detect_probe;
	rdrv_state_type power_state;
	int failures = 0;
	int cmp_count = 0;
	int cyc = 0;
	int n;
	logic [31:0] rd;
	logic [1:0] rsp;
	logic [1:0] pc [3] = '{`RDRV_PIN_LOW, `RDRV_PIN_FLOAT, `RDRV_PIN_HIGH};
	rdrv_gain_type gx [3] = '{RDRV_GAIN_3DB, RDRV_GAIN_6DB, RDRV_GAIN_9DB};
	rdrv_emph_type ex [3] = '{RDRV_EMPH_0DB, RDRV_EMPH_M3P5DB, RDRV_EMPH_M6P2DB};

	rdrv_ctrl #(.PROBE_CYC(PROBE), .SETTLE_CYC(8), .IDLE_CYC(IDLE)) DUT (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.enable_pin, .ch1_rx_boost_select, .ch1_tx_swing_select, .ch1_tx_emphasis_select,
		.ch1_lfps_present(lfps[0]), .ch1_signal_present(sig[0]), .ch1_far_end_present(far[0]),
		.ch2_rx_boost_select, .ch2_tx_swing_select, .ch2_tx_emphasis_select,
		.ch2_lfps_present(lfps[1]), .ch2_signal_present(sig[1]), .ch2_far_end_present(far[1]),
		.ch1_gain, .ch1_swing, .ch1_emph, .ch2_gain, .ch2_swing, .ch2_emph,
		.rx_term_en, .redrive_en, .low_power, .rx_detect_probe, .power_state
	);

	rdrv_far_end_model FAR (.aclk, .rx_detect_probe, .attached(att), .far_end_present(far));

	// ----------------------------------------
	// clock, timeout and helpers
	// ----------------------------------------
	initial forever #25 aclk = ~aclk;

	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			stop_test();
		end
	end

	task automatic chk(input bit ok, input int ln);
		cmp_count++;
		if (!ok) begin
			failures++;
			$display("BAD %0t mismatch at line %0d", $time, ln);
		end
	endtask

	task automatic stop_test();
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// axi write: address and data offered together, dropped when taken
	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		forever begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid === 1'h1) break;
		end
		r = s_axi_bresp;
	endtask

	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		forever begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid === 1'h1) break;
		end
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask

	// bounded wait for a power mode, then let registered flags follow
	task automatic wait_st(input rdrv_state_type s, input int lim);
		repeat (lim) begin
			if (power_state === s) break;
			@(posedge aclk);
		end
		repeat (2) @(posedge aclk);
		`CHK(power_state, s);
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		`CHK(power_state, RDRV_SHUTDOWN);
		`CHK(rx_term_en, 1'h0);
		axr(8'h0C, rd, rsp);
		`CHK(rsp, `RDRV_RESP_SLVERR);
		`CHK(rd, 32'h0);
		axw(`RDRV_STATUS_OFFSET, 32'hFFFFFFFF, rsp);
		`CHK(rsp, `RDRV_RESP_OKAY);
		// every select code, the two channels walk the codes in opposite order
		for (int i = 0; i < 3; i++) begin
			ch1_rx_boost_select <= pc[i];
			ch1_tx_emphasis_select <= pc[i];
			ch1_tx_swing_select <= i[0];
			ch2_rx_boost_select <= pc[2-i];
			ch2_tx_emphasis_select <= pc[2-i];
			ch2_tx_swing_select <= ~i[0];
			repeat (8) @(posedge aclk);
			`CHK(ch1_gain, gx[i]);
			`CHK(ch2_gain, gx[2-i]);
			`CHK(ch1_emph, ex[i]);
			`CHK(ch2_emph, ex[2-i]);
			`CHK(ch1_swing, rdrv_swing_type'(i[0]));
			`CHK(ch2_swing, rdrv_swing_type'(~i[0]));
			axr(`RDRV_SETTINGS_OFFSET, rd, rsp);
			`CHK(rd & 32'h1F1F, {19'h0, ex[2-i], ~i[0], gx[2-i], 3'h0, ex[i], i[0], gx[i]});
		end
		// lfps on channel 1 only, channel 2 keeps its own emphasis
		lfps <= 2'h1;
		ch2_tx_emphasis_select <= `RDRV_PIN_FLOAT;
		repeat (8) @(posedge aclk);
		`CHK(ch1_emph, RDRV_EMPH_0DB);
		`CHK(ch2_emph, RDRV_EMPH_M3P5DB);
		lfps <= 2'h0;
		repeat (8) @(posedge aclk);
		`CHK(ch1_emph, RDRV_EMPH_M6P2DB);
		// one load only: no termination, no U0
		att <= 2'h1;
		repeat (3 * PROBE) @(posedge aclk);
		`CHK(power_state, RDRV_DISCONNECT);
		`CHK(rx_term_en, 1'h0);
		att <= 2'h3;
		wait_st(RDRV_U0, 3 * PROBE);
		`CHK(rx_term_en, 1'h1);
		`CHK(redrive_en, 1'h1);
		axr(`RDRV_STATUS_OFFSET, rd, rsp);
		`CHK(rd[4:0], 5'h1E);
		sig <= 2'h2;
		repeat (5 * IDLE) @(posedge aclk);
		`CHK(power_state, RDRV_U0);
		sig <= 2'h0;
		wait_st(RDRV_U2U3, 3 * IDLE);
		`CHK(low_power, 1'h1);
		n = 0;
		while (rx_detect_probe !== 1'h1 && n < 2 * PROBE) begin
			@(posedge aclk);
			n++;
		end
		`CHK(rx_detect_probe, 1'h1);
		att <= 2'h1;
		wait_st(RDRV_DISCONNECT, 3 * PROBE);
		`CHK(rx_term_en, 1'h0);
		// enable pin drops the machine out of U0
		att <= 2'h3;
		wait_st(RDRV_U0, 3 * PROBE);
		enable_pin <= 1'h0;
		wait_st(RDRV_SHUTDOWN, 20);
		`CHK(redrive_en, 1'h0);
		`CHK(rx_term_en, 1'h0);
		enable_pin <= 1'h1;
		wait_st(RDRV_DISCONNECT, 20);
		// probe request starts a window long before the divider would
		axw(`RDRV_CTRL_OFFSET, 32'h2, rsp);
		repeat (3) @(posedge aclk);
		`CHK(rx_detect_probe, 1'h1);
		axw(`RDRV_CTRL_OFFSET, 32'h1, rsp);
		wait_st(RDRV_SHUTDOWN, 20);
		axr(`RDRV_CTRL_OFFSET, rd, rsp);
		`CHK(rd[1:0], 2'h1);
		axw(`RDRV_CTRL_OFFSET, 32'h0, rsp);
		wait_st(RDRV_U0, 4 * PROBE);
		stop_test();
	end
endmodule
